// ===== logic/rtcb_top.sv
// rtc core around control register b: index/data port access, update sequencing,
// periodic/alarm/update-ended events and the interrupt request output
// assumes host i/o strobes synchronous to CLK_SYS, one cycle each
`timescale 1ns/1ps
`include "rtcb_consts.svh"

module rtcb_top
  import rtcb_pkg::*;
#(
  parameter int unsigned TICK_CYC = `RTCB_TICK_CYC
)
(
  input  wire logic       CLK_SYS,
  input  wire logic       RESET_N,
  input  wire logic       POWER_SENSE_RESET_N,
  input  wire logic [7:0] IO_ADDR,
  input  wire logic       IO_WR,
  input  wire logic       IO_RD,
  input  wire rtcb_byte_t IO_WDATA,
  output rtcb_byte_t      IO_RDATA,
  output logic            IRQ,
  output logic            SQW_OUT
);

  localparam logic [`RTCB_TICK_W-1:0] TICK_LAST = `RTCB_TICK_W'(TICK_CYC - 1);
  localparam logic [2:0]              LEAD_LAST = 3'(`RTCB_UPD_LEAD_CYC - 1);

  logic [6:0]              index_q;
  logic [`RTCB_TICK_W-1:0] tick_cnt_q;
  logic [7:0]              tick_idx_q;
  logic                    tick;
  logic                    sec_evt;
  logic                    per_evt;
  rtcb_upd_t               upd_state_q;
  logic [2:0]              lead_cnt_q;
  logic                    cal_step;
  logic                    cal_done;
  logic [3:0]              rate_select_q;
  logic [2:0]              divider_ctl_q;
  logic                    update_inhibit_q;
  logic                    hour24_q;
  logic                    dst_enable_q;
  logic                    periodic_irq_enable_q;
  logic                    alarm_irq_enable_q;
  logic                    update_end_irq_enable_q;
  logic                    periodic_flag_q;
  logic                    alarm_flag_q;
  logic                    update_end_flag_q;
  logic                    irq_request_flag;
  logic                    valid_ram_q;
  rtcb_byte_t              sec_alarm_q;
  rtcb_byte_t              min_alarm_q;
  rtcb_byte_t              hour_alarm_q;
  rtcb_byte_t              cal_sec;
  rtcb_byte_t              cal_min;
  rtcb_byte_t              cal_hour;
  rtcb_byte_t              cal_dow;
  rtcb_byte_t              cal_date;
  rtcb_byte_t              cal_month;
  rtcb_byte_t              cal_year;
  rtcb_byte_t              rd_mux;
  logic                    wr_index;
  logic                    wr_data;
  logic                    rd_data;
  logic                    alarm_hit;
  logic                    flags_rd_clr;

  function automatic logic alarm_match(input rtcb_byte_t alarm, input rtcb_byte_t now);
    alarm_match = (alarm[7:6] == `RTCB_ALARM_DC) || (alarm == now);
  endfunction

  // tick-index mask for the periodic rate; code 0 means no periodic event
  function automatic logic [7:0] rate_mask(input logic [3:0] rs);
    unique case (rs)
      4'hD:    rate_mask = 8'(`RTCB_PER_C13_TICKS - 1);
      4'hE:    rate_mask = 8'(`RTCB_PER_C14_TICKS - 1);
      4'hF:    rate_mask = 8'(`RTCB_PER_C15_TICKS - 1);
      4'h8:    rate_mask = 8'h00;
      4'h9:    rate_mask = 8'h01;
      4'hA:    rate_mask = 8'h03;
      4'hB:    rate_mask = 8'h07;
      4'hC:    rate_mask = 8'h0F;
      default: rate_mask = 8'h00;
    endcase
  endfunction

  // host port decode
  assign wr_index     = IO_WR && (IO_ADDR == `RTCB_PORT_INDEX);
  assign wr_data      = IO_WR && (IO_ADDR == `RTCB_PORT_DATA);
  assign rd_data      = IO_RD && (IO_ADDR == `RTCB_PORT_DATA);
  assign flags_rd_clr = rd_data && (index_q == `RTCB_IDX_FLAGS);

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N)
      index_q <= 7'h00;
    else if (wr_index)
      index_q <= IO_WDATA[6:0];
  end

  // timebase: 256 ticks per second
  assign tick    = (tick_cnt_q == TICK_LAST);
  assign sec_evt = tick && (tick_idx_q == 8'hFF);
  assign per_evt = tick && (rate_select_q != 4'h0) && ((tick_idx_q & rate_mask(rate_select_q)) == rate_mask(rate_select_q));

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      tick_cnt_q <= '0;
      tick_idx_q <= 8'h00;
    end else if (tick) begin
      tick_cnt_q <= '0;
      tick_idx_q <= tick_idx_q + 8'h01;
    end else begin
      tick_cnt_q <= tick_cnt_q + `RTCB_TICK_W'(1);
    end
  end

  // update sequencer: lead phase shows update-in-progress, then one step
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      upd_state_q <= RTCB_UPD_IDLE;
      lead_cnt_q  <= 3'h0;
    end else begin
      unique case (upd_state_q)
        RTCB_UPD_IDLE: begin
          lead_cnt_q <= 3'h0;
          if (sec_evt && !update_inhibit_q)
            upd_state_q <= RTCB_UPD_LEAD;
        end
        RTCB_UPD_LEAD: begin
          lead_cnt_q <= lead_cnt_q + 3'h1;
          if (update_inhibit_q)
            upd_state_q <= RTCB_UPD_IDLE;
          else if (lead_cnt_q == LEAD_LAST)
            upd_state_q <= RTCB_UPD_RUN;
        end
        RTCB_UPD_RUN: begin
          upd_state_q <= RTCB_UPD_IDLE;
        end
      endcase
    end
  end

  assign cal_step = (upd_state_q == RTCB_UPD_RUN) && !update_inhibit_q;

  rtcb_calendar u_calendar (
    .clk     (CLK_SYS),
    .psr_n   (POWER_SENSE_RESET_N),
    .step    (cal_step),
    .mode24  (hour24_q),
    .dst_en  (dst_enable_q),
    .wr_en   (wr_data),
    .wr_idx  (index_q),
    .wr_data (IO_WDATA),
    .sec_q   (cal_sec),
    .min_q   (cal_min),
    .hour_q  (cal_hour),
    .dow_q   (cal_dow),
    .date_q  (cal_date),
    .month_q (cal_month),
    .year_q  (cal_year),
    .done_q  (cal_done)
  );

  // alarm bytes
  always_ff @(posedge CLK_SYS) begin
    if (!POWER_SENSE_RESET_N) begin
      sec_alarm_q  <= 8'h00;
      min_alarm_q  <= 8'h00;
      hour_alarm_q <= 8'h00;
    end else if (wr_data) begin
      if (index_q == `RTCB_IDX_SEC_ALM)
        sec_alarm_q <= IO_WDATA;
      if (index_q == `RTCB_IDX_MIN_ALM)
        min_alarm_q <= IO_WDATA;
      if (index_q == `RTCB_IDX_HOUR_ALM)
        hour_alarm_q <= IO_WDATA;
    end
  end

  assign alarm_hit = alarm_match(sec_alarm_q, cal_sec) && alarm_match(min_alarm_q, cal_min)
                     && alarm_match(hour_alarm_q, cal_hour);

  // control register a: rate and divider bits
  always_ff @(posedge CLK_SYS) begin
    if (!POWER_SENSE_RESET_N) begin
      rate_select_q <= `RTCB_RATE_INIT;
      divider_ctl_q <= 3'h0;
    end else if (wr_data && index_q == `RTCB_IDX_CTRL_A) begin
      rate_select_q <= IO_WDATA[3:0];
      divider_ctl_q <= IO_WDATA[6:4];
    end
  end

  // control register b, bits kept through the reset input
  always_ff @(posedge CLK_SYS) begin
    if (!POWER_SENSE_RESET_N) begin
      update_inhibit_q <= 1'b0;
      hour24_q         <= 1'b0;
      dst_enable_q     <= 1'b0;
    end else if (wr_data && index_q == `RTCB_IDX_CTRL_B) begin
      update_inhibit_q <= IO_WDATA[`RTCB_B_SET];
      hour24_q         <= IO_WDATA[`RTCB_B_H24];
      dst_enable_q     <= IO_WDATA[`RTCB_B_DSE];
    end
  end

  // control register b, enables cleared by the reset input
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      periodic_irq_enable_q   <= 1'b0;
      alarm_irq_enable_q      <= 1'b0;
      update_end_irq_enable_q <= 1'b0;
    end else if (wr_data && index_q == `RTCB_IDX_CTRL_B) begin
      periodic_irq_enable_q   <= IO_WDATA[`RTCB_B_PIE];
      alarm_irq_enable_q      <= IO_WDATA[`RTCB_B_AIE];
      if (IO_WDATA[`RTCB_B_SET] && !update_inhibit_q)
        update_end_irq_enable_q <= 1'b0;
      else
        update_end_irq_enable_q <= IO_WDATA[`RTCB_B_UIE];
    end
  end

  // event flags: a set in the clearing read cycle survives
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      periodic_flag_q   <= 1'b0;
      alarm_flag_q      <= 1'b0;
      update_end_flag_q <= 1'b0;
    end else if (!POWER_SENSE_RESET_N) begin
      periodic_flag_q   <= 1'b0;
      alarm_flag_q      <= 1'b0;
      update_end_flag_q <= 1'b0;
    end else begin
      periodic_flag_q   <= per_evt || (periodic_flag_q && !flags_rd_clr);
      alarm_flag_q      <= (cal_done && alarm_hit) || (alarm_flag_q && !flags_rd_clr);
      update_end_flag_q <= cal_done || (update_end_flag_q && !flags_rd_clr);
    end
  end

  assign irq_request_flag = (periodic_flag_q && periodic_irq_enable_q)
                            || (alarm_flag_q && alarm_irq_enable_q)
                            || (update_end_flag_q && update_end_irq_enable_q);

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N)
      IRQ <= 1'b0;
    else
      IRQ <= irq_request_flag;
  end

  // square wave generation is permanently off
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N)
      SQW_OUT <= 1'b0;
    else
      SQW_OUT <= 1'b0;
  end

  // valid ram and time bit
  always_ff @(posedge CLK_SYS) begin
    if (!POWER_SENSE_RESET_N)
      valid_ram_q <= 1'b0;
    else if (rd_data && index_q == `RTCB_IDX_VALID)
      valid_ram_q <= 1'b1;
  end

  // read data selection
  always_comb begin
    rd_mux = 8'h00;
    if (IO_ADDR == `RTCB_PORT_INDEX) begin
      rd_mux = {1'b0, index_q};
    end else begin
      unique case (index_q)
        `RTCB_IDX_SEC:      rd_mux = cal_sec;
        `RTCB_IDX_SEC_ALM:  rd_mux = sec_alarm_q;
        `RTCB_IDX_MIN:      rd_mux = cal_min;
        `RTCB_IDX_MIN_ALM:  rd_mux = min_alarm_q;
        `RTCB_IDX_HOUR:     rd_mux = cal_hour;
        `RTCB_IDX_HOUR_ALM: rd_mux = hour_alarm_q;
        `RTCB_IDX_DOW:      rd_mux = cal_dow;
        `RTCB_IDX_DATE:     rd_mux = cal_date;
        `RTCB_IDX_MONTH:    rd_mux = cal_month;
        `RTCB_IDX_YEAR:     rd_mux = cal_year;
        `RTCB_IDX_CTRL_A: begin
          rd_mux[`RTCB_A_UIP] = (upd_state_q != RTCB_UPD_IDLE);
          rd_mux[6:4]         = divider_ctl_q;
          rd_mux[3:0]         = rate_select_q;
        end
        `RTCB_IDX_CTRL_B: begin
          rd_mux[`RTCB_B_SET]  = update_inhibit_q;
          rd_mux[`RTCB_B_PIE]  = periodic_irq_enable_q;
          rd_mux[`RTCB_B_AIE]  = alarm_irq_enable_q;
          rd_mux[`RTCB_B_UIE]  = update_end_irq_enable_q;
          rd_mux[`RTCB_B_SQWE] = 1'b0;
          rd_mux[`RTCB_B_DFMT] = 1'b0;
          rd_mux[`RTCB_B_H24]  = hour24_q;
          rd_mux[`RTCB_B_DSE]  = dst_enable_q;
        end
        `RTCB_IDX_FLAGS: begin
          rd_mux[`RTCB_C_IRQ_REQUEST_FLAG] = irq_request_flag;
          rd_mux[`RTCB_C_PF]   = periodic_flag_q;
          rd_mux[`RTCB_C_AF]   = alarm_flag_q;
          rd_mux[`RTCB_C_UF]   = update_end_flag_q;
        end
        `RTCB_IDX_VALID: begin
          rd_mux[`RTCB_D_VRT] = valid_ram_q;
        end
        default: rd_mux = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N)
      IO_RDATA <= 8'h00;
    else if (IO_RD)
      IO_RDATA <= rd_mux;
  end

endmodule // rtcb_top

// ===== logic/rtcb_consts.svh
// constants for the rtc control block: ports, indices, bit positions, reset values, timing
// assumes inclusion by bare name from the design and bench files
`ifndef RTCB_CONSTS_SVH
`define RTCB_CONSTS_SVH

`define RTCB_PORT_INDEX     8'h70
`define RTCB_PORT_DATA      8'h71

`define RTCB_IDX_SEC        7'h00
`define RTCB_IDX_SEC_ALM    7'h01
`define RTCB_IDX_MIN        7'h02
`define RTCB_IDX_MIN_ALM    7'h03
`define RTCB_IDX_HOUR       7'h04
`define RTCB_IDX_HOUR_ALM   7'h05
`define RTCB_IDX_DOW        7'h06
`define RTCB_IDX_DATE       7'h07
`define RTCB_IDX_MONTH      7'h08
`define RTCB_IDX_YEAR       7'h09
`define RTCB_IDX_CTRL_A     7'h0A
`define RTCB_IDX_CTRL_B     7'h0B
`define RTCB_IDX_FLAGS      7'h0C
`define RTCB_IDX_VALID      7'h0D

`define RTCB_B_SET          7
`define RTCB_B_PIE          6
`define RTCB_B_AIE          5
`define RTCB_B_UIE          4
`define RTCB_B_SQWE         3
`define RTCB_B_DFMT         2
`define RTCB_B_H24          1
`define RTCB_B_DSE          0
`define RTCB_A_UIP          7
`define RTCB_C_IRQ_REQUEST_FLAG         7
`define RTCB_C_PF           6
`define RTCB_C_AF           5
`define RTCB_C_UF           4
`define RTCB_D_VRT          7

`define RTCB_ALARM_DC       2'h3
`define RTCB_SEC_INIT       8'h00
`define RTCB_MIN_INIT       8'h00
`define RTCB_HOUR_INIT      8'h12
`define RTCB_DOW_INIT       8'h01
`define RTCB_DATE_INIT      8'h01
`define RTCB_MONTH_INIT     8'h01
`define RTCB_YEAR_INIT      8'h00
`define RTCB_RATE_INIT      4'h0

`define RTCB_CLK_KHZ        100000
`define RTCB_SECOND_MS      1000
`define RTCB_TICKS_PER_SEC  256
`define RTCB_TICK_CYC       ((`RTCB_SECOND_MS * `RTCB_CLK_KHZ) / `RTCB_TICKS_PER_SEC)
`define RTCB_TICK_W         19
`define RTCB_PER_C13_MS     125
`define RTCB_PER_C14_MS     250
`define RTCB_PER_C15_MS     500
`define RTCB_PER_C13_TICKS  ((`RTCB_PER_C13_MS * `RTCB_TICKS_PER_SEC) / `RTCB_SECOND_MS)
`define RTCB_PER_C14_TICKS  ((`RTCB_PER_C14_MS * `RTCB_TICKS_PER_SEC) / `RTCB_SECOND_MS)
`define RTCB_PER_C15_TICKS  ((`RTCB_PER_C15_MS * `RTCB_TICKS_PER_SEC) / `RTCB_SECOND_MS)
`define RTCB_UPD_LEAD_CYC   4

`endif

// ===== logic/rtcb_pkg.sv
// types shared by the rtc control block modules
// assumes nothing beyond a sv compiler
package rtcb_pkg;

  typedef logic [7:0] rtcb_byte_t;

  typedef enum logic [1:0] {
    RTCB_UPD_IDLE,
    RTCB_UPD_LEAD,
    RTCB_UPD_RUN
  } rtcb_upd_t;

endpackage

// ===== logic/rtcb_calendar.sv
// bcd time and calendar counters with 12/24 hour and daylight saving steps
// assumes one-cycle step pulses from the update sequencer and host writes by index
`timescale 1ns/1ps
`include "rtcb_consts.svh"

module rtcb_calendar
  import rtcb_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       psr_n,
  input  wire logic       step,
  input  wire logic       mode24,
  input  wire logic       dst_en,
  input  wire logic       wr_en,
  input  wire logic [6:0] wr_idx,
  input  wire rtcb_byte_t wr_data,
  output rtcb_byte_t      sec_q,
  output rtcb_byte_t      min_q,
  output rtcb_byte_t      hour_q,
  output rtcb_byte_t      dow_q,
  output rtcb_byte_t      date_q,
  output rtcb_byte_t      month_q,
  output rtcb_byte_t      year_q,
  output logic            done_q
);

  logic       fall_done_q;
  logic       spring_day;
  logic       fall_day;
  logic [8:0] hour_nx;

  function automatic rtcb_byte_t bcd_inc(input rtcb_byte_t v);
    if (v == 8'h99)
      bcd_inc = 8'h00;
    else if (v[3:0] == 4'h9)
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    else
      bcd_inc = v + 8'h01;
  endfunction

  function automatic rtcb_byte_t days_in_month(input rtcb_byte_t m, input rtcb_byte_t y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6) : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    unique case (m)
      8'h02:                      days_in_month = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: days_in_month = 8'h30;
      default:                    days_in_month = 8'h31;
    endcase
  endfunction

  // returns {day_roll, next_hour}
  function automatic logic [8:0] hour_next(input rtcb_byte_t h, input logic h24);
    if (h24) begin
      hour_next = (h == 8'h23) ? {1'b1, 8'h00} : {1'b0, bcd_inc(h)};
    end else if (h[6:0] == 7'h11) begin
      hour_next = {h[7], ~h[7], 7'h12};
    end else if (h[6:0] == 7'h12) begin
      hour_next = {1'b0, h[7], 7'h01};
    end else begin
      // pm bit rides on top; increments below 12 never carry into bit 7
      hour_next    = {1'b0, bcd_inc({1'b0, h[6:0]})};
      hour_next[7] = h[7];
    end
  endfunction

  assign hour_nx = hour_next(hour_q, mode24);

  assign spring_day = (month_q == 8'h04) && (dow_q == 8'h01) && (date_q <= 8'h07);
  assign fall_day   = (month_q == 8'h10) && (dow_q == 8'h01) && (date_q >= 8'h25);

  always_ff @(posedge clk) begin
    if (!psr_n) begin
      sec_q       <= `RTCB_SEC_INIT;
      min_q       <= `RTCB_MIN_INIT;
      hour_q      <= `RTCB_HOUR_INIT;
      dow_q       <= `RTCB_DOW_INIT;
      date_q      <= `RTCB_DATE_INIT;
      month_q     <= `RTCB_MONTH_INIT;
      year_q      <= `RTCB_YEAR_INIT;
      fall_done_q <= 1'b0;
    end else if (wr_en) begin
      unique case (wr_idx)
        `RTCB_IDX_SEC:   sec_q   <= wr_data;
        `RTCB_IDX_MIN:   min_q   <= wr_data;
        `RTCB_IDX_HOUR:  hour_q  <= wr_data;
        `RTCB_IDX_DOW:   dow_q   <= wr_data;
        `RTCB_IDX_DATE:  date_q  <= wr_data;
        `RTCB_IDX_MONTH: month_q <= wr_data;
        `RTCB_IDX_YEAR:  year_q  <= wr_data;
        default: ;
      endcase
    end else if (step) begin
      if (sec_q != 8'h59) begin
        sec_q <= bcd_inc(sec_q);
      end else begin
        sec_q <= 8'h00;
        if (min_q != 8'h59) begin
          min_q <= bcd_inc(min_q);
        end else begin
          min_q <= 8'h00;
          if (dst_en && spring_day && hour_q == 8'h01) begin
            hour_q <= 8'h03;
          end else if (dst_en && fall_day && hour_q == 8'h01 && !fall_done_q) begin
            hour_q      <= 8'h01;
            fall_done_q <= 1'b1;
          end else begin
            hour_q <= hour_nx[7:0];
            if (hour_nx[8]) begin
              fall_done_q <= 1'b0;
              dow_q       <= (dow_q == 8'h07) ? 8'h01 : bcd_inc(dow_q);
              if (date_q == days_in_month(month_q, year_q)) begin
                date_q <= 8'h01;
                if (month_q == 8'h12) begin
                  month_q <= 8'h01;
                  year_q  <= bcd_inc(year_q);
                end else begin
                  month_q <= bcd_inc(month_q);
                end
              end else begin
                date_q <= bcd_inc(date_q);
              end
            end
          end
        end
      end
    end
  end

  // counters are stable again one cycle after a step
  always_ff @(posedge clk) begin
    if (!psr_n)
      done_q <= 1'b0;
    else
      done_q <= step && !wr_en;
  end

endmodule // rtcb_calendar

// ===== tb/rtcb_monitor.sv
// checker for rtcb_top port behaviour around control register b
// assumes binding onto rtcb_top; shadows index and control b from host writes
`timescale 1ns/1ps
`include "rtcb_consts.svh"

module rtcb_monitor
  import rtcb_pkg::*;
#(
  parameter int unsigned TICK_CYC = `RTCB_TICK_CYC
)
(
  input wire logic       CLK_SYS,
  input wire logic       RESET_N,
  input wire logic       POWER_SENSE_RESET_N,
  input wire logic [7:0] IO_ADDR,
  input wire logic       IO_WR,
  input wire logic       IO_RD,
  input wire rtcb_byte_t IO_WDATA,
  input wire rtcb_byte_t IO_RDATA,
  input wire logic       IRQ,
  input wire logic       SQW_OUT
);
  logic [6:0] idx_q;
  logic [2:0] en_q;
  logic [2:0] keep_q;
  logic       wr_b;
  rtcb_byte_t ctl_w;

  assign wr_b  = IO_WR && IO_ADDR == `RTCB_PORT_DATA && idx_q == `RTCB_IDX_CTRL_B;
  assign ctl_w = {keep_q[2], en_q, 2'h0, keep_q[1:0]};

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      idx_q <= 7'h00;
    end else if (IO_WR && IO_ADDR == `RTCB_PORT_INDEX) begin
      idx_q <= IO_WDATA[6:0];
    end
  end

  // enables: uie dropped when the inhibit bit rises
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      en_q <= 3'h0;
    end else if (wr_b) begin
      en_q <= {IO_WDATA[6:5], IO_WDATA[4] & ~(IO_WDATA[7] & ~keep_q[2])};
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!POWER_SENSE_RESET_N) begin
      keep_q <= 3'h0;
    end else if (wr_b) begin
      keep_q <= {IO_WDATA[7], IO_WDATA[1:0]};
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);

  sequence rd_ctl_s;
    IO_RD && IO_ADDR == `RTCB_PORT_DATA && idx_q == `RTCB_IDX_CTRL_B;
  endsequence

  sequence wr_off_s;
    wr_b && IO_WDATA[6:5] == 2'h0 && (!IO_WDATA[4] || (IO_WDATA[7] && !keep_q[2]));
  endsequence

  sqw_low_a: assert property (SQW_OUT == 1'b0)
    else $error("square wave output active");
  ctl_read_a: assert property (rd_ctl_s |=> IO_RDATA == $past(ctl_w))
    else $error("control b read value wrong");
  fixed_bits_a: assert property (rd_ctl_s |=> IO_RDATA[3:2] == 2'h0)
    else $error("fixed control bits read nonzero");
  irq_gate_a: assert property (IRQ |-> $past(en_q) != 3'h0)
    else $error("irq without any enable");
  irq_drop_a: assert property (wr_off_s |-> ##2 !IRQ)
    else $error("irq kept after enables cleared");
  rd_hold_a: assert property (!IO_RD |=> $stable(IO_RDATA))
    else $error("read data changed without read");
  idx_read_a: assert property (IO_RD && IO_ADDR == `RTCB_PORT_INDEX |=> IO_RDATA == {1'b0, $past(idx_q)})
    else $error("index port read wrong");
  irq_reset_a: assert property ($rose(RESET_N) |-> !IRQ)
    else $error("irq high after reset");
endmodule // rtcb_monitor

bind rtcb_top rtcb_monitor #(.TICK_CYC(TICK_CYC)) u_rtcb_monitor (
  .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .POWER_SENSE_RESET_N(POWER_SENSE_RESET_N), .IO_ADDR(IO_ADDR),
  .IO_WR(IO_WR), .IO_RD(IO_RD), .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA), .IRQ(IRQ), .SQW_OUT(SQW_OUT));

// ===== tb/rtcb_host_model.sv
// host model: byte cycles on the index and data i/o ports
// assumes strobes taken on the rising edge; drives on falling edges
`timescale 1ns/1ps
`include "rtcb_consts.svh"

module rtcb_host_model
  import rtcb_pkg::*;
(
  input  wire logic       clk,
  input  wire rtcb_byte_t io_rdata,
  output logic [7:0]      io_addr,
  output logic            io_wr,
  output logic            io_rd,
  output rtcb_byte_t      io_wdata
);
  initial begin
    io_addr  = 8'h00;
    io_wr    = 1'b0;
    io_rd    = 1'b0;
    io_wdata = 8'h00;
  end

  task automatic cyc(input logic [7:0] a, input logic w, input rtcb_byte_t d, output rtcb_byte_t q);
    @(negedge clk);
    io_addr  = a;
    io_wdata = d;
    io_wr    = w;
    io_rd    = ~w;
    @(negedge clk);
    q        = io_rdata;
    io_wr    = 1'b0;
    io_rd    = 1'b0;
    // idle bus shows no stale value
    io_addr  = ~a;
    io_wdata = ~d;
  endtask

  task automatic reg_wr(input logic [6:0] idx, input rtcb_byte_t v);
    rtcb_byte_t q;
    cyc(`RTCB_PORT_INDEX, 1'b1, {1'b0, idx}, q);
    cyc(`RTCB_PORT_DATA, 1'b1, v, q);
  endtask

  task automatic reg_rd(input logic [6:0] idx, output rtcb_byte_t v);
    cyc(`RTCB_PORT_INDEX, 1'b1, {1'b0, idx}, v);
    cyc(`RTCB_PORT_DATA, 1'b0, 8'h00, v);
  endtask
endmodule // rtcb_host_model

// ===== tb/tb_top.sv
// top bench for rtcb_top: control register b, updates, alarms, periodic rates, time steps
// assumes the host model for port cycles and a shortened timebase
`timescale 1ns/1ps
`include "rtcb_consts.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end

module tb_top
  import rtcb_pkg::*;
;
  localparam int unsigned TICK = 4;
  localparam int          SEC  = 256 * TICK;
  localparam rtcb_byte_t  CB[5]  = '{8'h01, 8'h00, 8'h01, 8'h02, 8'h00};
  localparam rtcb_byte_t  MON[5] = '{8'h04, 8'h04, 8'h10, 8'h01, 8'h01};
  localparam rtcb_byte_t  DAT[5] = '{8'h01, 8'h01, 8'h25, 8'h01, 8'h01};
  localparam rtcb_byte_t  HR[5]  = '{8'h01, 8'h01, 8'h01, 8'h23, 8'h91};
  localparam rtcb_byte_t  EXP[5] = '{8'h03, 8'h02, 8'h01, 8'h00, 8'h12};
  logic       clk_sys = 1'b0;
  logic       reset_n = 1'b0;
  logic       psr_n   = 1'b0;
  logic [7:0] io_addr;
  logic       io_wr;
  logic       io_rd;
  rtcb_byte_t io_wdata;
  rtcb_byte_t io_rdata;
  logic       irq;
  logic       sqw;
  rtcb_byte_t v;
  logic       seen;
  int         bad_count = 0;
  int         compares  = 0;
  int         cycles    = 0;
  realtime    t0;
  realtime    t1;

  always #5 clk_sys = ~clk_sys;

  rtcb_top #(.TICK_CYC(TICK)) u_rtcb_top (.CLK_SYS(clk_sys), .RESET_N(reset_n), .POWER_SENSE_RESET_N(psr_n),
    .IO_ADDR(io_addr), .IO_WR(io_wr), .IO_RD(io_rd), .IO_WDATA(io_wdata), .IO_RDATA(io_rdata), .IRQ(irq),
    .SQW_OUT(sqw));
  rtcb_host_model u_rtcb_host_model (.clk(clk_sys), .io_rdata(io_rdata), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata));

  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      end_sim();
    end
  end

  task automatic wr(input logic [6:0] i, input rtcb_byte_t d);
    u_rtcb_host_model.reg_wr(i, d);
  endtask

  task automatic rd(input logic [6:0] i, output rtcb_byte_t d);
    u_rtcb_host_model.reg_rd(i, d);
  endtask

  task automatic rd_chk(input logic [6:0] i, input rtcb_byte_t e, input rtcb_byte_t m);
    rtcb_byte_t d;
    u_rtcb_host_model.reg_rd(i, d);
    `CHK(d & m, e)
  endtask

  // bounded wait for the irq line to reach a level
  task automatic wait_irq(input logic lvl, output logic hit);
    int n;
    n = 0;
    // irq drops one cycle after a clearing read; skip that stale cycle
    @(negedge clk_sys);
    while (irq !== lvl && n < SEC + 100) begin
      @(negedge clk_sys);
      n++;
    end
    hit = (irq === lvl);
  endtask

  task automatic pulse_reset();
    @(negedge clk_sys);
    reset_n = 1'b0;
    @(negedge clk_sys);
    reset_n = 1'b1;
  endtask

  initial begin
    repeat (10) @(negedge clk_sys);
    reset_n = 1'b1;
    psr_n   = 1'b1;
    rd_chk(`RTCB_IDX_CTRL_B, 8'h00, 8'hFF);
    wr(`RTCB_IDX_CTRL_B, 8'h7F);
    rd_chk(`RTCB_IDX_CTRL_B, 8'h73, 8'hFF);
    u_rtcb_host_model.cyc(`RTCB_PORT_INDEX, 1'b0, 8'h00, v);
    `CHK(v, 8'h0B)
    pulse_reset();
    rd_chk(`RTCB_IDX_CTRL_B, 8'h03, 8'hFF);
    wr(`RTCB_IDX_CTRL_B, 8'h13);
    wr(`RTCB_IDX_CTRL_B, 8'h93);
    rd_chk(`RTCB_IDX_CTRL_B, 8'h83, 8'hFF);
    pulse_reset();
    rd_chk(`RTCB_IDX_CTRL_B, 8'h83, 8'hFF);
    $display("test done: control b");
    wr(`RTCB_IDX_SEC, 8'h10);
    rd(`RTCB_IDX_FLAGS, v);
    repeat (SEC + 200) @(negedge clk_sys);
    rd_chk(`RTCB_IDX_SEC, 8'h10, 8'hFF);
    rd_chk(`RTCB_IDX_FLAGS, 8'h00, 8'h10);
    wr(`RTCB_IDX_CTRL_B, 8'h10);
    wait_irq(1'b1, seen);
    `CHK(seen, 1'b1)
    rd_chk(`RTCB_IDX_SEC, 8'h11, 8'hFF);
    rd_chk(`RTCB_IDX_FLAGS, 8'h10, 8'h10);
    wr(`RTCB_IDX_CTRL_B, 8'h00);
    rd(`RTCB_IDX_FLAGS, v);
    wait_irq(1'b1, seen);
    `CHK(seen, 1'b0)
    rd_chk(`RTCB_IDX_FLAGS, 8'h10, 8'h10);
    $display("test done: update cycle");
    wr(`RTCB_IDX_HOUR_ALM, 8'hC0);
    wr(`RTCB_IDX_MIN_ALM, 8'hC0);
    for (int k = 0; k < 2; k++) begin
      wr(`RTCB_IDX_SEC_ALM, (k == 0) ? 8'hC0 : 8'h45);
      wr(`RTCB_IDX_CTRL_B, 8'h20);
      rd(`RTCB_IDX_FLAGS, v);
      wait_irq(1'b1, seen);
      `CHK(seen, k == 0)
      wr(`RTCB_IDX_CTRL_B, 8'h00);
    end
    $display("test done: alarm");
    for (int c = 13; c < 16; c++) begin
      wr(`RTCB_IDX_CTRL_A, 8'(c));
      wr(`RTCB_IDX_CTRL_B, 8'h40);
      rd(`RTCB_IDX_FLAGS, v);
      wait_irq(1'b0, seen);
      wait_irq(1'b1, seen);
      t0 = $realtime;
      rd(`RTCB_IDX_FLAGS, v);
      wait_irq(1'b0, seen);
      wait_irq(1'b1, seen);
      t1 = $realtime;
      `CHK(int'((t1 - t0) / 10.0), (32 << (c - 13)) * TICK)
      wr(`RTCB_IDX_CTRL_B, 8'h00);
      rd_chk(`RTCB_IDX_CTRL_A, 8'(c), 8'h0F);
    end
    $display("test done: periodic");
    for (int k = 0; k < 5; k++) begin
      wr(`RTCB_IDX_CTRL_B, 8'h80 | CB[k]);
      wr(`RTCB_IDX_MONTH, MON[k]);
      wr(`RTCB_IDX_DATE, DAT[k]);
      wr(`RTCB_IDX_DOW, 8'h01);
      wr(`RTCB_IDX_HOUR, HR[k]);
      wr(`RTCB_IDX_MIN, 8'h59);
      wr(`RTCB_IDX_SEC, 8'h59);
      wr(`RTCB_IDX_CTRL_B, 8'h10 | CB[k]);
      rd(`RTCB_IDX_FLAGS, v);
      wait_irq(1'b1, seen);
      rd_chk(`RTCB_IDX_HOUR, EXP[k], 8'hFF);
      rd_chk(`RTCB_IDX_MIN, 8'h00, 8'hFF);
    end
    $display("test done: time steps");
    end_sim();
  end
endmodule // tb_top
